// ===== verilog/thermal_low_regs.svh
// register offsets, reset values, field positions and timing counts
`ifndef THERMAL_LOW_REGS_SVH
`define THERMAL_LOW_REGS_SVH
`define IDEAL_SEL_ADDR 8'h14
`define IDEAL_EN_ADDR 8'h15
`define LOW_FLAGS_ADDR 8'h33
`define FAULT_FLAGS_ADDR 8'h36
`define IDEAL_SEL_RESET 8'h18
`define IDEAL_SEL_LAST 8'h3f
`define IDEAL_EN_RESET 8'h00
`define FLAGS_RESET 8'h00
`define IDEAL_EN_MASK 8'h0e
`define FLAGS_MASK 8'h0f
`define FAULT_MASK 8'h0e
`define DETECT_TIME_US 3000
`define CLOCK_MHZ 100
`define DETECT_CYCLES (`DETECT_TIME_US * `CLOCK_MHZ)
`endif

// ===== verilog/thermal_low_pkg.sv
// types shared by the monitor files
`default_nettype none
package thermal_low_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DETECT = 3'b010,
    ST_CONVERT = 3'b100
  } seq_state_e;
  // request to the analog front end
  typedef struct packed {
    logic start;
    logic [1:0] channel;
    logic custom_ideality;
    logic [7:0] ideality_code;
  } conv_req_s;
  // register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage
`default_nettype wire

// ===== verilog/fault_timer.sv
// down counter that times the diode fault detection window
`timescale 1ns/1ns
`default_nettype none
module fault_timer #(
  parameter int CYCLES = 300000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o
);
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic run_q;
  logic run_d;
  logic done_q;
  logic done_d;

  // load on start, pulse done at zero
  always_comb
  begin
    count_d = count_q;
    run_d = run_q;
    done_d = 1'b0;
    if (start_i)
    begin
      count_d = 32'(CYCLES - 1);
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (count_q == 32'h0)
      begin
        run_d = 1'b0;
        done_d = 1'b1;
      end
      else
        count_d = count_q - 32'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= 32'h0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
endmodule
`default_nettype wire

// ===== verilog/thermal_low_status.sv
// under-temperature flags, diode fault handling and ideality selection
// Function
// - After each conversion a channel's low flag (bit 0 local, 1-3 remote) sets when below its low limit.
// - The low flag register resets to zero and bits 7 to 4 read zero.
// - A remote channel is flagged faulty when the front end reports open or shorted inputs.
// - A faulty channel drives no alarm and sets no over or under temperature flag.
// - A fault sets the channel's fault status bit and stores a zero result.
// - About the first 3 ms of each channel slot is spent on fault detection.
// - On a fault the channel's conversion is dropped and the next channel starts at once.
// - Each remote channel uses factor 1.008 or the shared custom code per its enable bit.
// - Ideality changes apply to later conversions and stored results hold until a new one ends.
// - The custom selection register maps codes from 0x00 upward and resets to 0x18.
// - Status bits clear on a successful read; low bits set again after a conversion and fault bits after a detect window fault, if still true.
// - Ideality enable bits 1 to 3 pick custom per remote channel, other bits reserved.
`timescale 1ns/1ns
`default_nettype none
`include "thermal_low_regs.svh"
module thermal_low_status #(
  parameter int DETECT_CYCLES = `DETECT_CYCLES,
  parameter int CHANNELS = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire thermal_low_pkg::reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic run_i,
  input wire logic fault_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_temp_i,
  input wire logic [15:0] low_limit_i,
  input wire logic [15:0] high_limit_i,
  output thermal_low_pkg::conv_req_s conv_req_o,
  output logic [CHANNELS-1:0] high_event_o,
  output logic thermal_alarm_output_o,
  output logic [1:0] result_channel_o,
  output logic [15:0] result_temp_o,
  output logic result_valid_o
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ideal_sel_q, ideal_sel_d;
  logic [7:0] ideal_en_q, ideal_en_d;
  logic [7:0] low_flags_q, low_flags_d;
  logic [7:0] fault_flags_q, fault_flags_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] set_low, set_fault;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  thermal_low_pkg::seq_state_e state_q, state_d;
  logic [1:0] chan_q, chan_d;
  thermal_low_pkg::conv_req_s req_q, req_d;
  logic [CHANNELS-1:0] high_q, high_d;
  logic alarm_q, alarm_d;
  logic [1:0] res_ch_q, res_ch_d;
  logic [15:0] res_temp_q, res_temp_d;
  logic res_v_q, res_v_d;
  logic timer_start, timer_done;
  logic is_remote;

  fault_timer #(
    .CYCLES(DETECT_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(timer_start),
    .done_o(timer_done)
  );

  assign is_remote = (chan_q != 2'h0);

  // channel slot sequencing and result capture
  always_comb
  begin
    state_d = state_q;
    chan_d = chan_q;
    req_d = req_q;
    req_d.start = 1'b0;
    high_d = '0;
    alarm_d = alarm_q;
    res_ch_d = res_ch_q;
    res_temp_d = res_temp_q;
    res_v_d = 1'b0;
    set_low = 8'h00;
    set_fault = 8'h00;
    timer_start = 1'b0;
    unique case (state_q)
      thermal_low_pkg::ST_IDLE:
      begin
        if (run_i)
        begin
          state_d = thermal_low_pkg::ST_DETECT;
          timer_start = 1'b1;
        end
      end
      thermal_low_pkg::ST_DETECT:
      begin
        if (is_remote && fault_i)
        begin
          set_fault[chan_q] = 1'b1;
          res_temp_d = 16'h0000;
          res_ch_d = chan_q;
          res_v_d = 1'b1;
          alarm_d = 1'b0;
          chan_d = chan_q + 2'h1;
          state_d = run_i ? thermal_low_pkg::ST_DETECT : thermal_low_pkg::ST_IDLE;
          timer_start = run_i;
        end
        else if (timer_done)
        begin
          // ideality sampled only at conversion start
          req_d.start = 1'b1;
          req_d.channel = chan_q;
          req_d.custom_ideality = is_remote && ideal_en_q[chan_q];
          req_d.ideality_code = ideal_sel_q;
          state_d = thermal_low_pkg::ST_CONVERT;
        end
      end
      thermal_low_pkg::ST_CONVERT:
      begin
        if (conv_done_i)
        begin
          res_temp_d = conv_temp_i;
          res_ch_d = chan_q;
          res_v_d = 1'b1;
          // signed compare of two's complement data
          if ($signed(conv_temp_i) < $signed(low_limit_i))
            set_low[chan_q] = 1'b1;
          high_d[chan_q] = $signed(conv_temp_i) > $signed(high_limit_i);
          alarm_d = $signed(conv_temp_i) > $signed(high_limit_i);
          chan_d = chan_q + 2'h1;
          state_d = run_i ? thermal_low_pkg::ST_DETECT : thermal_low_pkg::ST_IDLE;
          timer_start = run_i;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= thermal_low_pkg::ST_IDLE;
      chan_q <= 2'h0;
      req_q <= '0;
      high_q <= '0;
      alarm_q <= 1'b0;
      res_ch_q <= 2'h0;
      res_temp_q <= 16'h0000;
      res_v_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      chan_q <= chan_d;
      req_q <= req_d;
      high_q <= high_d;
      alarm_q <= alarm_d;
      res_ch_q <= res_ch_d;
      res_temp_q <= res_temp_d;
      res_v_q <= res_v_d;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  // writes, read data and clear-on-read with set winning
  always_comb
  begin
    ideal_sel_d = ideal_sel_q;
    ideal_en_d = ideal_en_q;
    low_flags_d = low_flags_q;
    fault_flags_d = fault_flags_q;
    rdata_d = rdata_q;
    if (reg_req_i.wr)
    begin
      if (reg_req_i.addr == `IDEAL_SEL_ADDR)
        ideal_sel_d = reg_req_i.wdata;
      if (reg_req_i.addr == `IDEAL_EN_ADDR)
        ideal_en_d = reg_req_i.wdata & `IDEAL_EN_MASK;
    end
    if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        `IDEAL_SEL_ADDR: rdata_d = ideal_sel_q;
        `IDEAL_EN_ADDR: rdata_d = ideal_en_q;
        `LOW_FLAGS_ADDR:
        begin
          rdata_d = low_flags_q;
          low_flags_d = 8'h00;
        end
        `FAULT_FLAGS_ADDR:
        begin
          rdata_d = fault_flags_q;
          fault_flags_d = 8'h00;
        end
        default: rdata_d = 8'h00;
      endcase
    end
    low_flags_d = (low_flags_d | set_low) & `FLAGS_MASK;
    fault_flags_d = (fault_flags_d | set_fault) & `FAULT_MASK;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ideal_sel_q <= `IDEAL_SEL_RESET;
      ideal_en_q <= `IDEAL_EN_RESET;
      low_flags_q <= `FLAGS_RESET;
      fault_flags_q <= `FLAGS_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      ideal_sel_q <= ideal_sel_d;
      ideal_en_q <= ideal_en_d;
      low_flags_q <= low_flags_d;
      fault_flags_q <= fault_flags_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign conv_req_o = req_q;
  assign high_event_o = high_q;
  assign thermal_alarm_output_o = alarm_q;
  assign result_channel_o = res_ch_q;
  assign result_temp_o = res_temp_q;
  assign result_valid_o = res_v_q;
endmodule
`default_nettype wire

// ===== sim/thermal_low_status_props.sv
// assertions on the ports of the under-temperature status block
`timescale 1ns/1ns
`default_nettype none
module thermal_low_status_props #(
  parameter int DETECT_CYCLES = 20,
  parameter int CHANNELS = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire thermal_low_pkg::reg_req_s reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic run_i,
  input wire logic conv_done_i,
  input wire thermal_low_pkg::conv_req_s conv_req_o,
  input wire logic [CHANNELS-1:0] high_event_o,
  input wire logic thermal_alarm_output_o,
  input wire logic [1:0] result_channel_o,
  input wire logic [15:0] result_temp_o,
  input wire logic result_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  int win_q;
  // cycles since the current detect window opened; a slot still finishes
  // after the run level drops, so only a result restarts the count
  always_ff @(posedge clock_i)
    win_q <= (!rst_n_i || result_valid_o) ? 0 : win_q + 1;
  // a result that no conversion produced is a fault result
  sequence s_fault_res;
    result_valid_o && !$past(conv_done_i);
  endsequence
  sequence s_rd(a);
    reg_req_i.rd && reg_req_i.addr == a;
  endsequence
  property p_low_rsvd; s_rd(8'h33) |=> reg_rdata_o[7:4] == 4'h0; endproperty
  a_low_rsvd: assert property (p_low_rsvd) else $error("low reserved set");
  property p_flt_rsvd; s_rd(8'h36) |=> (reg_rdata_o & 8'hf1) == 8'h00; endproperty
  a_flt_rsvd: assert property (p_flt_rsvd) else $error("fault reserved set");
  property p_done_res; conv_done_i |=> result_valid_o; endproperty
  a_done_res: assert property (p_done_res) else $error("no result");
  property p_flt_zero; s_fault_res |-> result_temp_o == 16'h0 && result_channel_o != 2'h0; endproperty
  a_flt_zero: assert property (p_flt_zero) else $error("fault result");
  property p_flt_quiet; s_fault_res |-> ##[0:1] !thermal_alarm_output_o && high_event_o == '0; endproperty
  a_flt_quiet: assert property (p_flt_quiet) else $error("fault alarm");
  property p_flt_next; s_fault_res |=> !conv_req_o.start [*8]; endproperty
  a_flt_next: assert property (p_flt_next) else $error("no new window");
  property p_window; conv_req_o.start |-> win_q >= DETECT_CYCLES - 2; endproperty
  a_window: assert property (p_window) else $error("window short");
  property p_local; conv_req_o.start && conv_req_o.channel == 2'h0 |-> !conv_req_o.custom_ideality; endproperty
  a_local: assert property (p_local) else $error("local custom");
endmodule
bind thermal_low_status thermal_low_status_props #(
  .DETECT_CYCLES(DETECT_CYCLES),
  .CHANNELS(CHANNELS)
) u_props (
  .clock_i, .rst_n_i, .reg_req_i, .reg_rdata_o, .run_i, .conv_done_i, .conv_req_o,
  .high_event_o, .thermal_alarm_output_o, .result_channel_o, .result_temp_o, .result_valid_o
);
`default_nettype wire

// ===== sim/front_end_model.sv
// behavioural analog front end: fault level, conversion delay, results
`timescale 1ns/1ns
`default_nettype none
module front_end_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire thermal_low_pkg::conv_req_s req_i,
  input wire logic res_valid_i,
  input wire logic [1:0] res_ch_i,
  input wire logic [3:0] bad_i,
  output logic fault_o,
  output logic done_o,
  output logic [15:0] temp_o
);
  logic [15:0] tab [4] = '{16'h0800, 16'h2000, 16'h0400, 16'h0100};
  logic [1:0] ch = 2'h0;
  logic [2:0] wait_n = 3'h0;
  logic cust [4];
  logic [7:0] code [4];
  int starts [4] = '{0, 0, 0, 0};
  // fault level of the channel now in its detect window; during the result
  // pulse the block has already moved on to the next channel
  assign fault_o = bad_i[res_valid_i ? 2'(res_ch_i + 2'h1) : ch];
  // five-cycle conversion; the idle data bus toggles
  always @(posedge clock_i)
  begin
    done_o <= wait_n == 3'h1;
    temp_o <= (wait_n == 3'h1) ? tab[ch] : ~temp_o;
    wait_n <= (wait_n != 3'h0) ? wait_n - 3'h1 : 3'h0;
    if (res_valid_i) ch <= res_ch_i + 2'h1;
    if (req_i.start)
    begin
      wait_n <= 3'h5;
      starts[req_i.channel] <= starts[req_i.channel] + 1;
      cust[req_i.channel] <= req_i.custom_ideality;
      code[req_i.channel] <= req_i.ideality_code;
    end
    if (!rst_n_i)
    begin
      ch <= 2'h0;
      wait_n <= 3'h0;
      temp_o <= 16'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_thermal_low_status.sv
// self-checking bench for the under-temperature status block
`timescale 1ns/1ns
`default_nettype none
module test_thermal_low_status;
  logic clock_i = 0;
  logic rst_n_i = 0;
  logic run_i = 0;
  logic [3:0] bad = 4'h0;
  thermal_low_pkg::reg_req_s rq = '0;
  thermal_low_pkg::conv_req_s creq;
  logic [7:0] rdata;
  logic flt, done, valid;
  logic [15:0] temp, rtemp;
  logic [1:0] rch;
  logic [15:0] res [4];
  logic alarm;
  logic [3:0] high;
  logic [3:0] hseen = 4'h0;
  logic al [4];
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  thermal_low_status #(.DETECT_CYCLES(20)) dut (
    .clock_i, .rst_n_i, .reg_req_i(rq), .reg_rdata_o(rdata), .run_i, .fault_i(flt),
    .conv_done_i(done), .conv_temp_i(temp), .low_limit_i(16'h1000), .high_limit_i(16'h1800),
    .conv_req_o(creq), .high_event_o(high), .thermal_alarm_output_o(alarm),
    .result_channel_o(rch),
    .result_temp_o(rtemp), .result_valid_o(valid));
  front_end_model fe (.clock_i, .rst_n_i, .req_i(creq), .res_valid_i(valid),
    .res_ch_i(rch), .bad_i(bad), .fault_o(flt), .done_o(done), .temp_o(temp));
  initial forever #5 clock_i = ~clock_i;
  // keeps results per channel and cuts a hang short
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (valid) res[rch] <= rtemp;
    // alarm level left by each channel's result, and every high event seen
    if (valid) al[rch] <= alarm;
    hseen <= hseen | high;
    if (cyc == 4000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one register write (w=1) or read (w=0)
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) #1 rq = '{w, !w, a, d};
    @(posedge clock_i) #1 rq = '0;
  endtask
  // runs the sequence until channel 3 reports, then stops it
  task automatic pass3();
    int n;
    n = 0;
    run_i = 1;
    while (!(valid === 1'b1 && rch === 2'h3) && n < 500)
    begin
      @(posedge clock_i) #1 n++;
    end
    run_i = 0;
    check(16'(n < 500), 16'h1);
  endtask
  task automatic t_reset();
    acc(0, 8'h14, 0); check(rdata, 8'h18);
    acc(0, 8'h15, 0); check(rdata, 8'h00);
    acc(0, 8'h33, 0); check(rdata, 8'h00);
    acc(0, 8'h36, 0); check(rdata, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_regs();
    acc(1, 8'h15, 8'hff); acc(0, 8'h15, 0); check(rdata, 8'h0e);
    acc(1, 8'h14, 8'h36); acc(0, 8'h14, 0); check(rdata, 8'h36);
    acc(1, 8'h33, 8'hff); acc(0, 8'h33, 0); check(rdata, 8'h00);
    acc(1, 8'h15, 8'h02);
    acc(1, 8'h14, 8'h05);
    $display("register access done");
  endtask
  task automatic t_fault();
    bad = 4'h4;
    pass3();
    check(res[2], 16'h0000);
    check(16'(fe.starts[2]), 16'h0);
    check(fe.cust[1], 1'b1); check(fe.code[1], 8'h05);
    check(fe.cust[3], 1'b0);
    check(al[1], 1'b1); check(al[2], 1'b0);
    check(hseen, 4'h2);
    acc(0, 8'h33, 0); check(rdata, 8'h09);
    acc(0, 8'h33, 0); check(rdata, 8'h00);
    acc(0, 8'h36, 0); check(rdata, 8'h04);
    acc(0, 8'h36, 0); check(rdata, 8'h00);
    $display("diode fault pass done");
  endtask
  task automatic t_again();
    acc(1, 8'h14, 8'h07);
    bad = 4'h0;
    pass3();
    check(fe.code[1], 8'h07);
    check(res[2], 16'h0400);
    acc(0, 8'h33, 0); check(rdata, 8'h0d);
    $display("second pass done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1 rst_n_i = 1;
    t_reset();
    t_regs();
    t_fault();
    t_again();
    close_out();
  end
endmodule
`default_nettype wire
